// ===== core/mpsc_regs.vh
`ifndef MPSC_REGS_VH
`define MPSC_REGS_VH

// ****************************************
// Top-level power state codes
// ****************************************
`define MPSC_ST_ACTIVE   2'h0
`define MPSC_ST_SLEEP    2'h1
`define MPSC_ST_PSM      2'h2
`define MPSC_ST_OFF      2'h3

// ****************************************
// Active sub-mode codes
// ****************************************
`define MPSC_SUB_FULL    2'h0
`define MPSC_SUB_IDLE    2'h1
`define MPSC_SUB_AIRPL   2'h2
`define MPSC_SUB_EDRX    2'h3

// ****************************************
// Timing
// ****************************************
`define MPSC_CLK_HZ        25000000
`define MPSC_TMR_W         32
`define MPSC_WAKE_MARGIN   32'h0000_0010
`define MPSC_BOOT_CYC      8'h10
`define MPSC_SLEEP_SRC_W   5

`endif

// ===== core/mpsc_controller.v
`timescale 1ns/1ps
`include "mpsc_regs.vh"

// ****************************************
// Behaviour notes
// ****************************************
// Power-on and reset request pins are active low.
// Power-on counts only while supply is present.
// Emergency off outranks every other transition.
// A reset edge with power-on held forces Active.
// Supply loss forces Off on the next edge.
// Active enters PSM only after the inactivity period.
// Sleep leaves for PSM as soon as PSM is accepted.
// Sleep falls back to Active when a qualifier drops.
// Only a timer wake from PSM sends the area update.
// A pin wake from PSM still runs the boot count.
// Boot count loads on every PSM exit to Active.
// Wake point sits a fixed margin before cycle end.
// Short cycles clamp the wake point to one cycle.
// Off is left on a power-on edge, or a reset edge with power-on held, with supply.
// Idle counter saturates instead of wrapping.
// Sub-mode holds its last value outside Active.
// Radio stays on in Sleep for reception windows.
// State code is two bits, not one-hot, to match the pins.

module mpsc_controller (
    input  wire        clk,
    input  wire        rst,
    input  wire        battery_supply,
    input  wire        power_on_n,
    input  wire        reset_in_n,
    input  wire [1:0]  sub_mode_req,
    input  wire        usb_attached,
    input  wire        usb_suspended,
    input  wire        term_ready,
    input  wire        stay_awake,
    input  wire        gpio_sleep_ok,
    input  wire        modem_msg_idle,
    input  wire        wake_trigger,
    input  wire        psm_accepted,
    input  wire [31:0] psm_cycle_cyc,
    input  wire [31:0] active_idle_cyc,
    input  wire        traffic,
    output reg  [1:0]  power_state,
    output reg  [1:0]  active_sub_mode,
    output reg         app_core_run,
    output reg         modem_drx,
    output reg         radio_on,
    output reg         boot_busy,
    output reg         tau_send,
    output reg         device_reset,
    output reg         emerg_off
);

    // ****************************************
    // Local state
    // ****************************************
    reg  [1:0]  st_q;
    reg  [1:0]  st_d;
    reg  [31:0] cyc_q;
    reg  [31:0] idle_q;
    reg  [7:0]  boot_q;
    reg         pon_q;
    reg         rin_q;
    reg         tau_pend_q;
    wire        pon_on;
    wire        rin_on;
    wire        pon_rise;
    wire        rin_fall;
    wire [31:0] wake_at;
    wire        wake_tmr;
    wire        sleep_ok;
    wire        idle_done;

    // ****************************************
    // Helpers
    // ****************************************
    // Boot finished and no update waiting
    function boot_clear;
        input [7:0] cnt;
        input       pend;
        begin
            boot_clear = (cnt == 8'h00) && !pend;
        end
    endfunction

    // Active-low pins
    assign pon_on   = ~power_on_n & battery_supply;
    assign rin_on   = ~reset_in_n;
    assign pon_rise = pon_on & ~pon_q;
    assign rin_fall = rin_on & ~rin_q;

    // Wakeup point sits a margin ahead of the cycle end
    assign wake_at  = (psm_cycle_cyc > `MPSC_WAKE_MARGIN) ?
                      psm_cycle_cyc - `MPSC_WAKE_MARGIN : 32'h0000_0001;
    assign wake_tmr = (st_q == `MPSC_ST_PSM) && (cyc_q >= wake_at);

    // Sleep qualifiers, all must agree
    assign sleep_ok = (~usb_attached | usb_suspended) & ~term_ready &
                      ~stay_awake & gpio_sleep_ok & modem_msg_idle;

    // Inactivity period spent with boot and update done
    assign idle_done = (idle_q >= active_idle_cyc) && boot_clear(boot_q, tau_pend_q);

    // ****************************************
    // Next state
    // ****************************************
    always @* begin
        st_d = st_q;
        case (st_q)
            `MPSC_ST_ACTIVE: begin
                if (psm_accepted && idle_done)
                    st_d = `MPSC_ST_PSM;
                else if (psm_accepted && boot_clear(boot_q, tau_pend_q))
                    st_d = `MPSC_ST_ACTIVE;
                else if (!psm_accepted && sleep_ok && !wake_trigger)
                    st_d = `MPSC_ST_SLEEP;
            end
            `MPSC_ST_SLEEP: begin
                if (psm_accepted)
                    st_d = `MPSC_ST_PSM;
                else if (wake_trigger || !sleep_ok)
                    st_d = `MPSC_ST_ACTIVE;
            end
            `MPSC_ST_PSM: begin
                if (wake_tmr || pon_on || rin_on)
                    st_d = `MPSC_ST_ACTIVE;
            end
            `MPSC_ST_OFF: begin
                if (pon_rise)
                    st_d = `MPSC_ST_ACTIVE;
            end
            default: st_d = `MPSC_ST_ACTIVE;
        endcase
        // Supply loss, or a reset request with power-on released, forces Off
        if (!battery_supply)
            st_d = `MPSC_ST_OFF;
        if (rin_on && !pon_on && st_q != `MPSC_ST_OFF)
            st_d = `MPSC_ST_OFF;
        else if (rin_fall && pon_on)
            st_d = `MPSC_ST_ACTIVE;
    end

    // ****************************************
    // State, timers and outputs
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q            <= `MPSC_ST_ACTIVE;
            cyc_q           <= 32'h0000_0000;
            idle_q          <= 32'h0000_0000;
            boot_q          <= 8'h00;
            pon_q           <= 1'b0;
            rin_q           <= 1'b0;
            tau_pend_q      <= 1'b0;
            power_state     <= `MPSC_ST_ACTIVE;
            active_sub_mode <= `MPSC_SUB_FULL;
            app_core_run    <= 1'b1;
            modem_drx       <= 1'b0;
            radio_on        <= 1'b1;
            boot_busy       <= 1'b0;
            tau_send        <= 1'b0;
            device_reset    <= 1'b0;
            emerg_off       <= 1'b0;
        end else begin
            st_q         <= st_d;
            pon_q        <= pon_on;
            rin_q        <= rin_on;
            power_state  <= st_d;
            tau_send     <= 1'b0;
            device_reset <= rin_fall & pon_on;
            emerg_off    <= rin_on & ~pon_on & (st_q != `MPSC_ST_OFF);
            // Dormant cycle counter runs only in PSM
            if (st_q == `MPSC_ST_PSM && st_d == `MPSC_ST_PSM)
                cyc_q <= cyc_q + 32'h0000_0001;
            else
                cyc_q <= 32'h0000_0000;
            // Timer wake boots processors then sends the update
            if (st_q == `MPSC_ST_PSM && st_d == `MPSC_ST_ACTIVE) begin
                boot_q     <= `MPSC_BOOT_CYC;
                tau_pend_q <= wake_tmr;
            end else if (boot_q != 8'h00) begin
                boot_q <= boot_q - 8'h01;
            end else if (tau_pend_q) begin
                tau_send   <= 1'b1;
                tau_pend_q <= 1'b0;
            end
            // Inactivity count after the update
            if (st_q != `MPSC_ST_ACTIVE || traffic || boot_q != 8'h00 || tau_pend_q)
                idle_q <= 32'h0000_0000;
            else if (idle_q != 32'hFFFF_FFFF)
                idle_q <= idle_q + 32'h0000_0001;
            // ****************************************
            // Output decode
            // ****************************************
            // Sub-mode follows request while active
            if (st_d == `MPSC_ST_ACTIVE)
                active_sub_mode <= sub_mode_req;
            boot_busy    <= (st_d == `MPSC_ST_ACTIVE) && (boot_q != 8'h00 ||
                            (st_q == `MPSC_ST_PSM));
            app_core_run <= (st_d == `MPSC_ST_ACTIVE);
            modem_drx    <= (st_d == `MPSC_ST_SLEEP) ||
                            (st_d == `MPSC_ST_ACTIVE && sub_mode_req == `MPSC_SUB_EDRX);
            radio_on     <= (st_d == `MPSC_ST_ACTIVE && sub_mode_req != `MPSC_SUB_AIRPL) ||
                            (st_d == `MPSC_ST_SLEEP);
        end
    end

endmodule

// ===== verification/mpsc_props.sv
`timescale 1ns/1ps
`include "mpsc_regs.vh"
// ****************************************
// Power state checker
// ****************************************
module mpsc_props (
    input wire       clk,
    input wire       rst,
    input wire       battery_supply,
    input wire       power_on_n,
    input wire       reset_in_n,
    input wire       wake_trigger,
    input wire       psm_accepted,
    input wire [1:0] power_state,
    input wire       boot_busy,
    input wire       tau_send,
    input wire       device_reset,
    input wire       emerg_off
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Supply present and no reset request
    wire ok;
    assign ok = battery_supply && reset_in_n;
    property p_emerg;
        !reset_in_n && power_on_n && power_state != `MPSC_ST_OFF |=> emerg_off;
    endproperty
    a_emerg: assert property (p_emerg) else $error("no emergency off");
    property p_reset;
        $fell(reset_in_n) && !power_on_n && power_state != `MPSC_ST_OFF
        |=> device_reset && power_state == `MPSC_ST_ACTIVE;
    endproperty
    a_reset: assert property (p_reset) else $error("reset request ignored");
    property p_supply;
        !battery_supply && reset_in_n |=> power_state == `MPSC_ST_OFF;
    endproperty
    a_supply: assert property (p_supply) else $error("on without supply");
    property p_on;
        power_state == `MPSC_ST_OFF && $fell(power_on_n) && ok |=> power_state == `MPSC_ST_ACTIVE;
    endproperty
    a_on: assert property (p_on) else $error("power-on did not wake");
    property p_boot;
        $rose(boot_busy) |-> boot_busy [*8] ##[8:10] !boot_busy;
    endproperty
    a_boot: assert property (p_boot) else $error("boot length wrong");
    property p_tau;
        $fell(boot_busy) && ok |-> ##[0:1] tau_send;
    endproperty
    a_tau: assert property (p_tau) else $error("no update after boot");
    property p_wake;
        power_state == `MPSC_ST_SLEEP && wake_trigger && !psm_accepted && ok && power_on_n
        |=> power_state == `MPSC_ST_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("sleep wake missed");
    property p_psm;
        power_state == `MPSC_ST_SLEEP && psm_accepted && !wake_trigger && ok && power_on_n
        |=> power_state == `MPSC_ST_PSM;
    endproperty
    a_psm: assert property (p_psm) else $error("stayed out of PSM");
    c_psm: cover property (power_state == `MPSC_ST_PSM);
    c_tau: cover property (tau_send);
    c_off: cover property (emerg_off);
endmodule
bind mpsc_controller mpsc_props mpsc_props_i (.clk, .rst, .battery_supply, .power_on_n,
    .reset_in_n, .wake_trigger, .psm_accepted, .power_state, .boot_busy, .tau_send,
    .device_reset, .emerg_off);

// ===== verification/mpsc_host.sv
`timescale 1ns/1ps
// ****************************************
// Host driving the request lines
// ****************************************
module mpsc_host (
    input  wire on_req,
    input  wire rst_req,
    output wire power_on_n,
    output wire reset_in_n
);
    // Active-low lines, released line driven high; requests come at the falling edge
    assign power_on_n = !on_req;
    assign reset_in_n = !rst_req;
endmodule

// ===== verification/module_power_state_controller_tb.sv
`timescale 1ns/1ps
`include "mpsc_regs.vh"
module module_power_state_controller_tb;
    logic        clk, rst, sup, on_req, rst_req, wake, psm, traffic;
    logic [1:0]  sub;
    logic [5:0]  q;
    logic [31:0] cyc, idle, seed, to;
    wire  [1:0]  st, subm;
    wire         pon_n, rin_n, boot, tau, run, drx, rad;
    int          errors, cmp_count, i;
    mpsc_host mpsc_host_i (.on_req, .rst_req, .power_on_n(pon_n), .reset_in_n(rin_n));
    mpsc_controller mpsc_controller_i (.clk, .rst, .battery_supply(sup), .power_on_n(pon_n),
        .reset_in_n(rin_n), .sub_mode_req(sub), .usb_attached(q[5]), .usb_suspended(q[4]),
        .term_ready(q[3]), .stay_awake(q[2]), .gpio_sleep_ok(q[1]), .modem_msg_idle(q[0]),
        .wake_trigger(wake), .psm_accepted(psm), .psm_cycle_cyc(cyc), .active_idle_cyc(idle),
        .traffic, .power_state(st), .active_sub_mode(subm), .app_core_run(run), .modem_drx(drx),
        .radio_on(rad), .boot_busy(boot), .tau_send(tau), .device_reset(), .emerg_off());
    function automatic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected state from the sleep qualifiers
    function automatic [1:0] exp_st(input [5:0] v);
        return ((!v[5] | v[4]) & !v[3] & !v[2] & v[1] & v[0]) ? `MPSC_ST_SLEEP : `MPSC_ST_ACTIVE;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Wait a bounded number of cycles for a state
    task automatic go(input logic [1:0] s, input int n);
        for (i = 0; i < n && st !== s; i++) @(negedge clk);
        chk(st, s);
    endtask
    task automatic report_and_stop();
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        if (++to == 32'h0000_1388) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst, sup, on_req, rst_req, wake, psm, traffic, sub, q} = {2'b11, 13'h0000};
        {cyc, idle, seed, to} = {32'h0000_0028, 32'h0000_000a, 32'haa34_629b, 32'h0000_0000};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(st, `MPSC_ST_ACTIVE);
        for (int k = 0; k < 4; k++) begin
            sub = k[1:0];
            repeat (2) @(negedge clk);
            chk(subm, k);
            chk(rad, (k == 2) ? 1'b0 : 1'b1);
        end
        for (int k = 0; k < 12; k++) begin
            q = (k == 0) ? 6'h03 : (k == 1) ? 6'h33 : (k == 2) ? 6'h23 : 6'(rnd());
            repeat (4) @(negedge clk);
            chk(st, exp_st(q));
        end
        q = 6'h03;
        go(`MPSC_ST_SLEEP, 4);
        repeat (2) @(negedge clk);
        chk(run, 1'b0);
        chk(drx, 1'b1);
        wake = 1'b1;
        go(`MPSC_ST_ACTIVE, 3);
        wake = 1'b0;
        go(`MPSC_ST_SLEEP, 4);
        psm = 1'b1;
        go(`MPSC_ST_PSM, 3);
        go(`MPSC_ST_ACTIVE, 26);
        for (i = 0; i < 30 && tau !== 1'b1; i++) @(negedge clk);
        chk(tau, 1'b1);
        traffic = 1'b1;
        repeat (20) @(negedge clk);
        chk(st, `MPSC_ST_ACTIVE);
        traffic = 1'b0;
        go(`MPSC_ST_PSM, 20);
        {on_req, rst_req} = 2'b11;
        go(`MPSC_ST_ACTIVE, 4);
        for (i = 0; i < 24 && boot !== 1'b0; i++) @(negedge clk);
        chk(boot, 1'b0);
        {on_req, rst_req, psm} = 3'b010;
        go(`MPSC_ST_OFF, 4);
        rst_req = 1'b0;
        repeat (5) @(negedge clk);
        chk(st, `MPSC_ST_OFF);
        on_req = 1'b1;
        go(`MPSC_ST_ACTIVE, 4);
        {on_req, sup} = 2'b00;
        go(`MPSC_ST_OFF, 4);
        sup = 1'b1;
        on_req = 1'b1;
        go(`MPSC_ST_ACTIVE, 4);
        report_and_stop();
    end
endmodule
